// ==== bench/fars_cmd_model.sv ====
// operator side of the sequencer: run switch and fault-reset key
// assumes the sequencer clock; every change lands 2 ns after a rising edge
`timescale 1ns/1ps
`default_nettype none
module fars_cmd_model #(
    parameter logic RUN_AT_PWRUP = 1'b1
) (
    input  wire logic clk,
    output var  logic run_cmd,
    output var  logic reset_cmd
);
    initial begin
        run_cmd   = RUN_AT_PWRUP;
        reset_cmd = 1'b0;
    end

    // remove then reapply is how the operator leaves a blocked start
    task automatic set_run(input logic v);
        @(posedge clk);
        #2 run_cmd = v;
    endtask

    // key held a few cycles so the synchroniser sees one clean rise
    task automatic press_reset();
        @(posedge clk);
        #2 reset_cmd = 1'b1;
        repeat (4) @(posedge clk);
        #2 reset_cmd = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== bench/test_fars_seq.sv ====
// self-checking bench for the fault and power-loss restart sequencer
// assumes short tick and trip counts: 20-cycle tick, 40-cycle supply trip
`timescale 1ns/1ps
`default_nettype none
module test_fars_seq
    import fars_pkg::*;
;
    logic        clk, rst_n, run_cmd, reset_cmd, supply_lost, fault_strobe;
    logic        restart_en, direct_start_en;
    fars_fault_t fault_code, fault_report;
    logic [12:0] retry_time_s;
    logic [3:0]  max_attempts, attempt_count;
    logic [7:0]  min_bb_ds, search_delay_ds;
    logic [11:0] ds_delay_ds;
    logic [1:0]  relay_one_sel, relay_two_sel, relay_three_sel;
    logic        output_enable, speed_search_req, fault_relay, fault_active;
    logic        relay_one_contact, relay_two_contact, relay_three_contact;
    logic        powerup_start_blocked_indication;
    int          n_mismatch, n_compared;

    fars_cmd_model i_fars_cmd_model (.clk(clk), .run_cmd(run_cmd), .reset_cmd(reset_cmd));

    fars_seq #(.UV_TRIP_CYC(40), .TICK_CYC(20)) i_fars_seq (
        .clk(clk), .rst_n(rst_n), .run_cmd(run_cmd), .reset_cmd(reset_cmd),
        .supply_lost(supply_lost), .fault_strobe(fault_strobe), .fault_code(fault_code),
        .restart_en(restart_en), .retry_time_s(retry_time_s), .max_attempts(max_attempts),
        .min_bb_ds(min_bb_ds), .search_delay_ds(search_delay_ds),
        .direct_start_en(direct_start_en), .ds_delay_ds(ds_delay_ds),
        .relay_one_sel(relay_one_sel), .relay_two_sel(relay_two_sel),
        .relay_three_sel(relay_three_sel), .output_enable(output_enable),
        .speed_search_req(speed_search_req), .fault_relay(fault_relay),
        .fault_active(fault_active), .fault_report(fault_report),
        .relay_one_contact(relay_one_contact), .relay_two_contact(relay_two_contact),
        .relay_three_contact(relay_three_contact),
        .powerup_start_blocked_indication(powerup_start_blocked_indication),
        .attempt_count(attempt_count));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic end_of_test();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: pick = output_enable;
            1: pick = fault_active;
            2: pick = speed_search_req;
            default: pick = fault_relay;
        endcase
    endfunction

    // bounded wait; a limit that runs out shows up as a mismatch
    task automatic wait_for(input int s, input logic v, input int lim);
        int i;
        for (i = 0; i < lim && pick(s) !== v; i++) step(1);
        chk(8'(pick(s)), 8'(v));
    endtask

    task automatic hit(input fars_fault_t c);
        step(1);
        fault_strobe = 1'b1;
        fault_code = c;
        step(1);
        fault_strobe = 1'b0;
        fault_code = FARS_F_NONE;
    endtask

    task automatic power_up(input logic ds);
        direct_start_en = ds;
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #2 rst_n = 1'b1;
    endtask

    task automatic rerun();
        i_fars_cmd_model.set_run(1'b0);
        step(6);
        i_fars_cmd_model.set_run(1'b1);
        wait_for(0, 1'b1, 100);
    endtask

    task automatic t_blocked();
        int i, flips;
        logic last;
        flips = 0;
        power_up(1'b0);
        last = powerup_start_blocked_indication;
        for (i = 0; i < 300; i++) begin
            step(1);
            if (powerup_start_blocked_indication !== last) flips++;
            last = powerup_start_blocked_indication;
        end
        chk(8'(output_enable), 8'h00);
        chk(8'(flips > 1), 8'h01);
        rerun();
        chk(8'(relay_three_contact), 8'h01);
    endtask

    task automatic t_retry();
        hit(FARS_F_EXCESS_CURRENT);
        step(1);
        chk(8'(output_enable), 8'h00);
        chk(8'(fault_active), 8'h01);
        chk(8'(fault_report), 8'(FARS_F_EXCESS_CURRENT));
        step(15);
        chk(8'(fault_active), 8'h01);
        wait_for(1, 1'b0, 60);
        chk(8'(attempt_count), 8'h01);
        wait_for(2, 1'b1, 60);
        chk(8'(relay_one_contact), 8'h01);
        chk(8'(output_enable), 8'h00);
        wait_for(0, 1'b1, 60);
    endtask

    task automatic t_lockout();
        hit(FARS_F_HIGH_TORQUE);
        wait_for(3, 1'b1, 120);
        chk(8'(output_enable), 8'h00);
        chk(8'(relay_two_contact), 8'h01);
        chk(8'(attempt_count), 8'h01);
        i_fars_cmd_model.press_reset();
        step(6);
        chk(8'(attempt_count), 8'h00);
        chk(8'(fault_relay), 8'h00);
    endtask

    // one-second retry interval: search must wait well past the baseblock
    task automatic t_spacing();
        retry_time_s = 13'h0001;
        relay_two_sel = 2'h3;
        hit(FARS_F_LOW_TORQUE);
        wait_for(1, 1'b0, 60);
        step(150);
        chk(8'(speed_search_req), 8'h00);
        wait_for(2, 1'b1, 80);
        chk(8'(relay_two_contact), 8'h00);
        wait_for(0, 1'b1, 60);
        chk(8'(attempt_count), 8'h01);
        retry_time_s = 13'h0000;
    endtask

    task automatic t_other();
        rerun();
        hit(FARS_F_OTHER);
        step(3);
        chk(8'(fault_relay), 8'h01);
        chk(8'(attempt_count), 8'h00);
        i_fars_cmd_model.press_reset();
        step(6);
    endtask

    task automatic t_sag();
        restart_en = 1'b0;
        rerun();
        supply_lost = 1'b1;
        step(8);
        supply_lost = 1'b0;
        wait_for(0, 1'b1, 20);
        supply_lost = 1'b1;
        step(30);
        chk(8'(fault_relay), 8'h00);
        wait_for(3, 1'b1, 80);
        chk(8'(fault_report), 8'(FARS_F_SUPPLY_SAG));
        supply_lost = 1'b0;
        i_fars_cmd_model.press_reset();
        restart_en = 1'b1;
        rerun();
        supply_lost = 1'b1;
        step(60);
        supply_lost = 1'b0;
        wait_for(0, 1'b1, 200);
        chk(8'(attempt_count), 8'h00);
    endtask

    task automatic t_direct();
        power_up(1'b1);
        step(100);
        chk(8'(output_enable), 8'h00);
        chk(8'(attempt_count), 8'h00);
        wait_for(0, 1'b1, 200);
    endtask

    initial begin
        n_mismatch = 0;
        n_compared = 0;
        rst_n = 1'b0;
        supply_lost = 1'b0;
        fault_strobe = 1'b0;
        fault_code = FARS_F_NONE;
        restart_en = 1'b1;
        direct_start_en = 1'b0;
        retry_time_s = 13'h0000;
        max_attempts = 4'h1;
        min_bb_ds = 8'h02;
        search_delay_ds = 8'h01;
        ds_delay_ds = 12'h000;
        relay_one_sel = 2'h1;
        relay_two_sel = 2'h0;
        relay_three_sel = 2'h2;
        t_blocked();
        t_retry();
        t_lockout();
        t_other();
        t_sag();
        t_spacing();
        t_direct();
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end
endmodule
`default_nettype wire

// ==== hdl/fars_pkg.sv ====
// types shared by the restart sequencer and its test bench
// assumes fars_regs.svh for the numeric constants
package fars_pkg;

    typedef enum logic [3:0] {
        FARS_F_NONE,
        FARS_F_SUPPLY_SAG,
        FARS_F_EXCESS_CURRENT,
        FARS_F_EXCESS_BUS_VOLTAGE,
        FARS_F_MOTOR_OVERLOAD,
        FARS_F_DRIVE_OVERLOAD,
        FARS_F_LOW_TORQUE,
        FARS_F_HIGH_TORQUE,
        FARS_F_INPUT_PHASE_MISSING,
        FARS_F_OUTPUT_PHASE_MISSING,
        FARS_F_EARTH_LEAK,
        FARS_F_OTHER
    } fars_fault_t;

    typedef enum logic [3:0] {
        FARS_S_PWRUP,
        FARS_S_IDLE,
        FARS_S_RUN,
        FARS_S_SAG,
        FARS_S_BASEBLOCK,
        FARS_S_RETRY,
        FARS_S_SEARCH,
        FARS_S_LOCKOUT,
        FARS_S_BLOCKED,
        FARS_S_DS_DELAY
    } fars_state_t;

endpackage

// ==== hdl/fars_regs.svh ====
// timing figures, limits and relay select codes for the restart sequencer
// assumes a single 40 MHz system clock
`ifndef FARS_REGS_SVH
`define FARS_REGS_SVH

`define FARS_CLK_HZ          40000000
`define FARS_UV_TRIP_MS      8
`define FARS_TICK_MS         100
`define FARS_CLR_MIN         10
`define FARS_CLR_TICKS       ((`FARS_CLR_MIN * 60 * 1000) / `FARS_TICK_MS)
`define FARS_RETRY_MAX_S     7200
`define FARS_ATTEMPT_MAX     4'ha
`define FARS_DS_MIN_DS       12'h00a
`define FARS_DS_MAX_DS       12'hbb8
`define FARS_FLASH_TICKS     3'h5
`define FARS_PWRUP_CYC       17'h00004
`define FARS_RSEL_FAULT      2'h0
`define FARS_RSEL_RESTART    2'h1
`define FARS_RSEL_RUN        2'h2
`define FARS_RSEL_OFF        2'h3

`endif

// ==== hdl/fars_seq.sv ====
// fault and power-loss restart sequencer of a motor drive
// assumes run, reset and supply-loss come from pins; fault_strobe/fault_code from on-chip detectors on clk
`timescale 1ns/1ps
`default_nettype none
`include "fars_regs.svh"
module fars_seq
    import fars_pkg::*;
#(
    parameter int unsigned UV_TRIP_CYC = (`FARS_CLK_HZ / 1000) * `FARS_UV_TRIP_MS,
    parameter int unsigned TICK_CYC    = (`FARS_CLK_HZ / 1000) * `FARS_TICK_MS
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        run_cmd,
    input  wire logic        reset_cmd,
    input  wire logic        supply_lost,
    input  wire logic        fault_strobe,
    input  wire fars_fault_t fault_code,
    input  wire logic        restart_en,
    input  wire logic [12:0] retry_time_s,
    input  wire logic [3:0]  max_attempts,
    input  wire logic [7:0]  min_bb_ds,
    input  wire logic [7:0]  search_delay_ds,
    input  wire logic        direct_start_en,
    input  wire logic [11:0] ds_delay_ds,
    input  wire logic [1:0]  relay_one_sel,
    input  wire logic [1:0]  relay_two_sel,
    input  wire logic [1:0]  relay_three_sel,
    output logic             output_enable,
    output logic             speed_search_req,
    output logic             fault_relay,
    output logic             fault_active,
    output fars_fault_t      fault_report,
    output logic             relay_one_contact,
    output logic             relay_two_contact,
    output logic             relay_three_contact,
    output logic             powerup_start_blocked_indication,
    output logic [3:0]       attempt_count
);
    localparam int unsigned UVW = $clog2(UV_TRIP_CYC + 1);

    function automatic logic limited_fault(input fars_fault_t c);
        return c inside {FARS_F_EXCESS_CURRENT, FARS_F_EXCESS_BUS_VOLTAGE, FARS_F_MOTOR_OVERLOAD,
                         FARS_F_DRIVE_OVERLOAD, FARS_F_LOW_TORQUE, FARS_F_HIGH_TORQUE,
                         FARS_F_INPUT_PHASE_MISSING, FARS_F_OUTPUT_PHASE_MISSING, FARS_F_EARTH_LEAK};
    endfunction

    function automatic logic relay_pick(input logic [1:0] sel, input logic flt, input logic rst_att,
                                        input logic run);
        unique case (sel)
            `FARS_RSEL_FAULT:   return flt;
            `FARS_RSEL_RESTART: return rst_att;
            `FARS_RSEL_RUN:     return run;
            `FARS_RSEL_OFF:     return 1'b0;
        endcase
    endfunction

    fars_tick_if tb ();
    fars_tick #(.TICK_CYC(TICK_CYC)) u_tick (.clk(clk), .rst_n(rst_n), .tb(tb));

    // pin synchronisers; first stage is read only by the second
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic       rst_prev_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg    <= '0;
            sync2_reg    <= '0;
            rst_prev_reg <= 1'b0;
        end else begin
            sync1_reg    <= {supply_lost, reset_cmd, run_cmd};
            sync2_reg    <= sync1_reg;
            rst_prev_reg <= sync2_reg[1];
        end
    end
    logic run_s;
    logic supply_s;
    logic reset_rise;
    assign run_s      = sync2_reg[0];
    assign supply_s   = sync2_reg[2];
    assign reset_rise = sync2_reg[1] & ~rst_prev_reg;

    fars_state_t state_reg, state_next;
    fars_fault_t code_reg, code_next;
    logic [16:0] tmr_reg, tmr_next;
    logic [12:0] clr_reg, clr_next;
    logic [UVW-1:0] uv_reg, uv_next;
    logic [3:0]  att_reg, att_next;
    logic [2:0]  fl_reg, fl_next;
    logic        flash_reg, flash_next;
    logic        fact_reg, fact_next;
    logic        ratt_reg, ratt_next;
    logic        oe_reg, ss_reg, fr_reg;
    logic [2:0]  rly_reg, rly_next;

    logic [3:0]  eff_max;
    logic [16:0] retry_ds;
    logic [16:0] extra_ds;
    logic [11:0] ds_eff;
    always_comb begin
        eff_max  = (max_attempts > `FARS_ATTEMPT_MAX) ? `FARS_ATTEMPT_MAX : max_attempts;
        retry_ds = 17'(retry_time_s) * 17'h0000a;
        extra_ds = (retry_ds > 17'(min_bb_ds)) ? retry_ds : 17'h0;
        ds_eff   = (ds_delay_ds < `FARS_DS_MIN_DS) ? `FARS_DS_MIN_DS :
                   (ds_delay_ds > `FARS_DS_MAX_DS) ? `FARS_DS_MAX_DS : ds_delay_ds;
    end

    always_comb begin
        state_next = state_reg;
        code_next  = code_reg;
        clr_next   = clr_reg;
        att_next   = att_reg;
        fact_next  = fact_reg;
        ratt_next  = ratt_reg;
        uv_next    = '0;
        unique case (state_reg)
            FARS_S_PWRUP: begin
                // wait for the synchronisers to carry the real run level
                if (tmr_reg >= `FARS_PWRUP_CYC) begin
                    if (run_s && direct_start_en) state_next = FARS_S_DS_DELAY;
                    else if (run_s)              state_next = FARS_S_BLOCKED;
                    else                         state_next = FARS_S_IDLE;
                end
            end
            FARS_S_IDLE:      if (run_s) state_next = FARS_S_RUN;
            FARS_S_RUN: begin
                if (supply_s) state_next = FARS_S_SAG;
                else if (!run_s) state_next = FARS_S_IDLE;
                if (tb.tick && att_reg != 4'h0) begin
                    clr_next = clr_reg + 13'h1;
                    if (clr_reg >= 13'(`FARS_CLR_TICKS - 1)) att_next = 4'h0;
                end
            end
            FARS_S_SAG: begin
                uv_next = (uv_reg >= UVW'(UV_TRIP_CYC)) ? uv_reg : uv_reg + UVW'(1);  // saturates, never wraps
                if (!supply_s) begin
                    if (restart_en) begin
                        state_next = FARS_S_BASEBLOCK;
                        code_next  = FARS_F_SUPPLY_SAG;
                        fact_next  = 1'b1;
                    end else begin
                        state_next = FARS_S_RUN;
                    end
                end else if (!restart_en && uv_reg >= UVW'(UV_TRIP_CYC)) begin
                    state_next = FARS_S_LOCKOUT;
                    code_next  = FARS_F_SUPPLY_SAG;
                    fact_next  = 1'b1;
                end
            end
            FARS_S_BASEBLOCK: begin
                if (tmr_reg >= 17'(min_bb_ds)) begin
                    fact_next = 1'b0;
                    if (code_reg == FARS_F_SUPPLY_SAG) begin
                        state_next = FARS_S_RETRY;
                        ratt_next  = 1'b1;
                    end else if (att_reg >= eff_max) begin
                        state_next = FARS_S_LOCKOUT;
                        fact_next  = 1'b1;
                    end else begin
                        state_next = FARS_S_RETRY;
                        att_next   = att_reg + 4'h1;
                        ratt_next  = 1'b1;
                    end
                end
            end
            FARS_S_RETRY:     if (tmr_reg >= extra_ds) state_next = FARS_S_SEARCH;
            FARS_S_SEARCH: begin
                if (tmr_reg >= 17'(search_delay_ds)) begin
                    state_next = run_s ? FARS_S_RUN : FARS_S_IDLE;
                    ratt_next  = 1'b0;
                    clr_next   = 13'h0;
                end
            end
            FARS_S_LOCKOUT: begin
                if (reset_rise) begin
                    state_next = FARS_S_IDLE;
                    fact_next  = 1'b0;
                    code_next  = FARS_F_NONE;
                end
            end
            FARS_S_BLOCKED:   if (!run_s) state_next = FARS_S_IDLE;
            FARS_S_DS_DELAY: begin
                if (!run_s) state_next = FARS_S_IDLE;
                else if (tmr_reg >= 17'(ds_eff)) state_next = FARS_S_RUN;
            end
        endcase
        // detector faults while the drive is live, about to be, or idle
        if (fault_strobe && fault_code != FARS_F_NONE &&
            state_reg inside {FARS_S_RUN, FARS_S_SAG, FARS_S_SEARCH, FARS_S_DS_DELAY, FARS_S_IDLE}) begin
            code_next = fault_code;
            fact_next = 1'b1;
            ratt_next = 1'b0;
            if (limited_fault(fault_code) || (fault_code == FARS_F_SUPPLY_SAG && restart_en))
                state_next = FARS_S_BASEBLOCK;
            else
                state_next = FARS_S_LOCKOUT;
        end
        if (reset_rise) att_next = 4'h0;
        if (state_next != state_reg)      tmr_next = 17'h0;
        else if (state_reg == FARS_S_PWRUP) tmr_next = tmr_reg + 17'h1;
        else if (tb.tick)                 tmr_next = tmr_reg + 17'h1;
        else                              tmr_next = tmr_reg;
        fl_next    = (state_reg != FARS_S_BLOCKED) ? 3'h0 :
                     (tb.tick ? ((fl_reg >= `FARS_FLASH_TICKS - 3'h1) ? 3'h0 : fl_reg + 3'h1) : fl_reg);
        flash_next = (state_next != FARS_S_BLOCKED) ? 1'b0 :
                     ((tb.tick && fl_reg >= `FARS_FLASH_TICKS - 3'h1) ? ~flash_reg : flash_reg);
        rly_next   = {relay_pick(relay_three_sel, state_next == FARS_S_LOCKOUT, ratt_next, state_next == FARS_S_RUN),
                      relay_pick(relay_two_sel,   state_next == FARS_S_LOCKOUT, ratt_next, state_next == FARS_S_RUN),
                      relay_pick(relay_one_sel,   state_next == FARS_S_LOCKOUT, ratt_next, state_next == FARS_S_RUN)};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= FARS_S_PWRUP;
            code_reg  <= FARS_F_NONE;
            tmr_reg   <= 17'h0;
            clr_reg   <= 13'h0;
            uv_reg    <= '0;
            att_reg   <= 4'h0;
            fl_reg    <= 3'h0;
            flash_reg <= 1'b0;
            fact_reg  <= 1'b0;
            ratt_reg  <= 1'b0;
            oe_reg    <= 1'b0;
            ss_reg    <= 1'b0;
            fr_reg    <= 1'b0;
            rly_reg   <= 3'h0;
        end else begin
            state_reg <= state_next;
            code_reg  <= code_next;
            tmr_reg   <= tmr_next;
            clr_reg   <= clr_next;
            uv_reg    <= uv_next;
            att_reg   <= att_next;
            fl_reg    <= fl_next;
            flash_reg <= flash_next;
            fact_reg  <= fact_next;
            ratt_reg  <= ratt_next;
            oe_reg    <= (state_next == FARS_S_RUN);
            ss_reg    <= (state_next == FARS_S_SEARCH);
            fr_reg    <= (state_next == FARS_S_LOCKOUT);
            rly_reg   <= rly_next;
        end
    end

    assign output_enable                    = oe_reg;
    assign speed_search_req                 = ss_reg;
    assign fault_relay                      = fr_reg;
    assign fault_active                     = fact_reg;
    assign fault_report                     = code_reg;
    assign relay_one_contact                = rly_reg[0];
    assign relay_two_contact                = rly_reg[1];
    assign relay_three_contact              = rly_reg[2];
    assign powerup_start_blocked_indication = flash_reg;
    assign attempt_count                    = att_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_fault_kills_out: assert property (fault_strobe && limited_fault(fault_code) && state_reg == FARS_S_RUN
        |=> !output_enable && fault_active) else $error("fault did not drop output");
    a_sag_trip_off: assert property (state_reg == FARS_S_SAG && restart_en && !fault_strobe |=> !fault_relay)
        else $error("sag trip with restart enabled");
    a_attempt_cap: assert property (attempt_count <= `FARS_ATTEMPT_MAX)
        else $error("attempt count above ten");
    a_sag_no_count: assert property (state_reg == FARS_S_BASEBLOCK && code_reg == FARS_F_SUPPLY_SAG
        |=> attempt_count == $past(attempt_count) || $past(reset_rise)) else $error("sag bumped counter");
    a_reset_clears: assert property (reset_rise |=> attempt_count == 4'h0)
        else $error("reset did not clear attempts");
    a_search_clean: assert property ($rose(speed_search_req) |-> !fault_active && !output_enable)
        else $error("search with fault active");
    a_lockout_relay: assert property (state_reg == FARS_S_LOCKOUT |-> fault_relay && !output_enable)
        else $error("lockout without fault contact");
    a_other_locks: assert property (fault_strobe && fault_code == FARS_F_OTHER && state_reg == FARS_S_RUN
        |=> state_reg == FARS_S_LOCKOUT) else $error("unlisted fault restarted");
    a_blocked_idle: assert property (state_reg == FARS_S_BLOCKED && run_s |=> !output_enable)
        else $error("blocked start drove motor");
    a_retry_spacing: assert property ($rose(speed_search_req) |-> $past(state_reg) == FARS_S_RETRY)
        else $error("search not preceded by retry wait");

    c_limited_restart: cover property (state_reg == FARS_S_SEARCH && attempt_count != 4'h0);
    c_sag_restart:     cover property (state_reg == FARS_S_BASEBLOCK && code_reg == FARS_F_SUPPLY_SAG);
    c_lockout:         cover property ($rose(fault_relay));
    c_direct_start:    cover property (state_reg == FARS_S_DS_DELAY ##1 state_reg == FARS_S_RUN);
endmodule
`default_nettype wire

// ==== hdl/fars_tick.sv ====
// divider making a one-cycle pulse every TICK_CYC clocks
// assumes clk and rst_n of the sequencer
`timescale 1ns/1ps
`default_nettype none
module fars_tick #(
    parameter int unsigned TICK_CYC = 4000000
) (
    input  wire logic   clk,
    input  wire logic   rst_n,
    fars_tick_if.src    tb
);
    localparam int unsigned W = $clog2(TICK_CYC);

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic         tick_reg;
    logic         tick_next;

    always_comb begin
        tick_next = (cnt_reg == W'(TICK_CYC - 1));
        cnt_next  = tick_next ? '0 : cnt_reg + W'(1);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tb.tick = tick_reg;
endmodule
`default_nettype wire

// ==== hdl/fars_tick_if.sv ====
// carries the 100 ms time base from the divider to the sequencer
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface fars_tick_if;
    logic tick;
    modport src (output tick);
    modport snk (input tick);
endinterface
`default_nettype wire
